// *** design/jtlm_lane_mapper.sv ***
// Transport-layer framer mapping samples onto sixteen lanes in two links.
`timescale 1ns/10ps

// Summary of operation
// (RL1) Only the twelve-bit CRC is made; the three-bit variant is refused.
// (RL2) A sync header mode input picks CRC-12 error detection or FEC.
// (RL3) One link mode value sets the format; unlisted modes are refused.
// (RL4) K minus one sets the multiframe length, within mode range and step.
// (RL5) Sixteen lanes form two links of eight; every mode uses both.
// (RL6) Each link uses its lowest lanes and powers down higher ones.
// (RL7) Link A reports the programmed device id, link B that plus one.
// (RL8) Lane id is the lane index within its link, zero to seven.
// (RL9) Bypass modes pack twelve-bit offset binary samples as the mode fixes.
// (RL10) Decimating modes pack sixteen-bit words: fifteen data bits then flag.
// (RL11) Every leftover tail or unused bit position is driven zero.
// (RL12) Each sample goes out most significant bit first.
// (RL13) Dual decimating modes: per-channel flags, one with I, one with Q.
// (RL14) Single decimating modes: I flag uses threshold zero, Q flag one.
// (RL15) Dual decimate-by-eight two-lane mode: A on link A lane zero, B on B.
// (RL16) The receiver must share mode, multiframe length, lanes and sync mode.
module jtlm_lane_mapper
  import jtlm_pkg::*;
(
  input wire logic core_clk, // System clock, 50 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic clkEn, // Freezes all state but the reset synchroniser while low.
  input wire logic cfgLoad, // Pulse: apply the mode, K-1 and sync header requests; deviceIdCfg is taken every enabled cycle.
  input wire logic [6:0] linkModeSelect, // Requested link mode.
  input wire logic [7:0] framesPerMultiframeMinusOne, // Requested K-1.
  input wire logic [1:0] syncHeaderMode, // Sync header use request.
  input wire logic [7:0] deviceIdCfg, // Programmed device id.
  input wire logic [PEAK_BITS-1:0] overrangeThresholdZero, // Threshold 0.
  input wire logic [PEAK_BITS-1:0] overrangeThresholdOne, // Threshold 1.
  input wire logic frameValid, // One frame of samples is present.
  input wire logic [DDC_BITS-1:0] ddcAI, // Channel A in-phase word.
  input wire logic [DDC_BITS-1:0] ddcAQ, // Channel A quadrature word.
  input wire logic [DDC_BITS-1:0] ddcBI, // Channel B in-phase word.
  input wire logic [DDC_BITS-1:0] ddcBQ, // Channel B quadrature word.
  input wire logic [PEAK_BITS-1:0] peakA, // Channel A input level.
  input wire logic [PEAK_BITS-1:0] peakB, // Channel B input level.
  input wire logic [BYP_BUS_BITS-1:0] bypassA, // Four A samples, first high.
  input wire logic [BYP_BUS_BITS-1:0] bypassB, // Four B samples, first high.
  output logic [NUM_LANES-1:0][LANE_BITS-1:0] laneData, // Frame per lane.
  output logic [NUM_LANES-1:0] laneEnable, // High for a powered lane.
  output logic [NUM_LANES-1:0][2:0] laneIdent, // Lane id per lane.
  output logic [7:0] deviceIdA, // Device id sent on link A.
  output logic [7:0] deviceIdB, // Device id sent on link B.
  output logic [2:0] octetsPerFrame, // Octets used per lane frame.
  output logic [6:0] activeMode, // Mode in force.
  output logic [7:0] activeKm1, // Multiframe length minus one.
  output logic syncUseCrc12, // Sync header carries CRC-12.
  output logic syncUseFec, // Sync header carries FEC.
  output logic frameOut, // Pulse: laneData holds a new frame.
  output logic multiframeEnd, // Pulse: that frame closes a multiframe.
  output logic cfgError // Last configuration request was refused.
);

  logic rstMeta;
  logic rstSync;
  logic [7:0] frameCount;
  logic [7:0] next_frameCount;
  logic [6:0] next_activeMode;
  logic [7:0] next_activeKm1;
  logic [7:0] next_deviceIdA;
  logic [7:0] next_deviceIdB;
  logic next_syncUseCrc12;
  logic next_syncUseFec;
  logic next_cfgError;
  logic [NUM_LANES-1:0] next_laneEnable;
  logic [NUM_LANES-1:0][2:0] next_laneIdent;
  logic [2:0] next_octetsPerFrame;
  logic [NUM_LANES-1:0][LANE_BITS-1:0] next_laneData;
  logic next_frameOut;
  logic next_multiframeEnd;
  logic reqLegal;
  logic flagA0;
  logic flagA1;
  logic flagB0;
  logic flagB1;

  function automatic logic [3:0] lanesUsed(input logic [6:0] mode);
    lanesUsed = (mode == MODE_DUAL_BYP_6L) ? LANES_BYP : LANES_DEC8;
  endfunction

  function automatic logic [LANES_PER_LINK-1:0] lowMask(
    input logic [3:0] count
  );
    logic [8:0] ones;
    ones = 9'h001 << count;
    lowMask = 8'(ones - 9'h001);
  endfunction

  function automatic logic [15:0] ddcWord(
    input logic [DDC_BITS-1:0] data,
    input logic flag
  );
    ddcWord = {data, flag};
  endfunction

  function automatic logic modeKnown(input logic [6:0] mode);
    modeKnown = (mode == MODE_SGL_DEC8_2L) || (mode == MODE_DUAL_BYP_6L) ||
                (mode == MODE_SGL_DEC8_2L_ALT) ||
                (mode == MODE_DUAL_DEC8_2L);
  endfunction

  function automatic logic kValid(
    input logic [6:0] mode,
    input logic [7:0] km1
  );
    logic [8:0] k;
    logic [8:0] step;
    k = {1'b0, km1} + 9'h001;
    step = (mode == MODE_DUAL_BYP_6L) ? K_STEP_BYP : K_STEP_DDC;
    kValid = (km1 >= KM1_MIN) && (km1 <= KM1_MAX) && ((k % step) == 9'h000);
  endfunction

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Configuration group.
  always_comb
  begin
    next_activeMode = activeMode;
    next_activeKm1 = activeKm1;
    next_deviceIdA = deviceIdA;
    next_deviceIdB = deviceIdB;
    next_syncUseCrc12 = syncUseCrc12;
    next_syncUseFec = syncUseFec;
    next_cfgError = cfgError;
    // (RL1) CRC-3 has no code and is refused.
    reqLegal = modeKnown(linkModeSelect) &&
               kValid(linkModeSelect, framesPerMultiframeMinusOne) &&
               ((syncHeaderMode == SHM_CRC12) || (syncHeaderMode == SHM_FEC));
    if (cfgLoad)
    begin
      next_cfgError = !reqLegal;
      // (RL3) only listed modes take effect.
      if (reqLegal)
      begin
        next_activeMode = linkModeSelect;
        // (RL4) multiframe length taken.
        next_activeKm1 = framesPerMultiframeMinusOne;
        // (RL2) sync header use.
        next_syncUseCrc12 = (syncHeaderMode == SHM_CRC12);
        next_syncUseFec = (syncHeaderMode == SHM_FEC);
      end
    end
    // (RL7) link B id is one above link A.
    next_deviceIdA = deviceIdCfg;
    next_deviceIdB = 8'(deviceIdCfg + 8'h01);
  end

  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      activeMode <= RST_MODE;
      activeKm1 <= RST_KM1;
      deviceIdA <= RST_DID;
      deviceIdB <= 8'(RST_DID + 8'h01);
      syncUseCrc12 <= 1'b1;
      syncUseFec <= 1'b0;
      cfgError <= 1'b0;
    end
    else if (clkEn)
    begin
      activeMode <= next_activeMode;
      activeKm1 <= next_activeKm1;
      deviceIdA <= next_deviceIdA;
      deviceIdB <= next_deviceIdB;
      syncUseCrc12 <= next_syncUseCrc12;
      syncUseFec <= next_syncUseFec;
      cfgError <= next_cfgError;
    end
  end

  // Lane and frame group.
  always_comb
  begin
    flagA0 = peakA > overrangeThresholdZero;
    flagA1 = peakA > overrangeThresholdOne;
    flagB0 = peakB > overrangeThresholdZero;
    flagB1 = peakB > overrangeThresholdOne;
    next_frameCount = frameCount;
    next_frameOut = frameValid;
    next_multiframeEnd = 1'b0;
    next_laneData = laneData;
    // (RL5) two links of eight lanes, both always used.
    // (RL6) lowest lanes on, the rest powered down.
    next_laneEnable = {lowMask(lanesUsed(activeMode)),
                       lowMask(lanesUsed(activeMode))};
    for (int i = 0; i < NUM_LANES; i++)
    begin
      // (RL8) lane id from index within link.
      next_laneIdent[i] = 3'(i % LANES_PER_LINK);
    end
    unique case (activeMode)
      MODE_DUAL_BYP_6L: next_octetsPerFrame = OCTETS_BYP;
      MODE_DUAL_DEC8_2L: next_octetsPerFrame = OCTETS_DUAL;
      default: next_octetsPerFrame = OCTETS_SGL;
    endcase
    if (frameValid)
    begin
      // (RL4) multiframe boundary after K frames.
      next_multiframeEnd = (frameCount >= activeKm1);
      next_frameCount = next_multiframeEnd ? 8'h00 : 8'(frameCount + 8'h01);
      // (RL11) unused positions and lanes are zero.
      next_laneData = '0;
      unique case (activeMode)
        MODE_DUAL_DEC8_2L:
        begin
          // (RL15) A on link A lane zero, B on link B lane zero.
          // (RL13) each channel flags against its own level.
          next_laneData[0] = {ddcWord(ddcAI, flagA0), ddcWord(ddcAQ, flagA1)};
          next_laneData[LANES_PER_LINK] = {ddcWord(ddcBI, flagB0),
                                           ddcWord(ddcBQ, flagB1)};
        end
        MODE_DUAL_BYP_6L:
        begin
          // (RL9) twelve-bit samples run across three lanes.
          // (RL12) first sample and its top bit lead.
          for (int i = 0; i < 3; i++)
          begin
            next_laneData[i][LANE_BITS-1 -: LANE_SLICE] =
              bypassA[BYP_BUS_BITS-1-LANE_SLICE*i -: LANE_SLICE];
            next_laneData[LANES_PER_LINK+i][LANE_BITS-1 -: LANE_SLICE] =
              bypassB[BYP_BUS_BITS-1-LANE_SLICE*i -: LANE_SLICE];
          end
        end
        default:
        begin
          // (RL10) fifteen-bit word then its flag.
          // (RL14) I flag on threshold zero, Q flag on threshold one.
          next_laneData[0][LANE_BITS-1 -: LANE_SLICE] =
            ddcWord(ddcAI, flagA0);
          next_laneData[LANES_PER_LINK][LANE_BITS-1 -: LANE_SLICE] =
            ddcWord(ddcAQ, flagA1);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      frameCount <= 8'h00;
      laneData <= '0;
      laneEnable <= '0;
      laneIdent <= '0;
      octetsPerFrame <= OCTETS_DUAL;
      frameOut <= 1'b0;
      multiframeEnd <= 1'b0;
    end
    else if (clkEn)
    begin
      frameCount <= next_frameCount;
      laneData <= next_laneData;
      laneEnable <= next_laneEnable;
      laneIdent <= next_laneIdent;
      octetsPerFrame <= next_octetsPerFrame;
      frameOut <= next_frameOut;
      multiframeEnd <= next_multiframeEnd;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstSync);

  sync_one_use_a: assert property (syncUseCrc12 != syncUseFec) // RL1
    else $error("Sync header use is not exactly one of CRC-12 and FEC.");

  fec_taken_a: assert property (clkEn && cfgLoad && reqLegal &&
    syncHeaderMode == SHM_FEC |=> syncUseFec && !syncUseCrc12) // RL2
    else $error("FEC request did not take effect.");

  mode_refused_a: assert property (clkEn && cfgLoad &&
    !modeKnown(linkModeSelect) |=> cfgError && $stable(activeMode)) // RL3
    else $error("Unlisted mode was not refused.");

  mf_end_a: assert property (clkEn && frameValid &&
    frameCount >= activeKm1 |=> multiframeEnd && frameCount == 8'h00) // RL4
    else $error("Multiframe did not close after K frames.");

  low_lanes_a: assert property (rstSync && clkEn |=>
    laneEnable[7:0] == lowMask(lanesUsed($past(activeMode))) &&
    laneEnable[15:8] == laneEnable[7:0]) // RL6
    else $error("Lane power pattern is wrong for the mode.");

  link_b_id_a: assert property (deviceIdB == 8'(deviceIdA + 8'h01)) // RL7
    else $error("Link B device id is not link A plus one.");

  lane_id_a: assert property (rstSync && clkEn |=> laneIdent[9] == 3'h1 &&
    laneIdent[7] == 3'h7 && laneIdent[8] == 3'h0) // RL8
    else $error("Lane id does not follow index within link.");

  dual_pack_a: assert property (clkEn && frameValid &&
    activeMode == MODE_DUAL_DEC8_2L |=>
    laneData[8] == {$past(ddcBI), $past(flagB0), $past(ddcBQ),
                    $past(flagB1)}) // RL15
    else $error("Link B lane zero does not carry channel B words.");

  idle_lane_zero_a: assert property (clkEn && frameValid |=>
    laneData[15] == '0 && laneData[7] == '0) // RL11
    else $error("Powered-down lane carries nonzero bits.");

  single_flag_a: assert property (clkEn && frameValid &&
    activeMode == MODE_SGL_DEC8_2L |=>
    laneData[8][16] == $past(flagA1) && laneData[0][15:0] == 16'h0000) // RL14
    else $error("Single-channel Q flag or tail bits are wrong.");

endmodule

// *** design/jtlm_pkg.sv ***
// Constants and types for the transport-layer lane mapper.
package jtlm_pkg;
  localparam int NUM_LINKS = 2;
  localparam int LANES_PER_LINK = 8;
  localparam int NUM_LANES = 16;
  localparam int LANE_BITS = 32;
  localparam int DDC_BITS = 15;
  localparam int BYP_BITS = 12;
  localparam int BYP_BUS_BITS = 48;
  localparam int LANE_SLICE = 16;
  localparam int PEAK_BITS = 12;

  // Accepted operating modes.
  localparam logic [6:0] MODE_SGL_DEC8_2L = 7'h17;
  localparam logic [6:0] MODE_DUAL_BYP_6L = 7'h21;
  localparam logic [6:0] MODE_SGL_DEC8_2L_ALT = 7'h26;
  localparam logic [6:0] MODE_DUAL_DEC8_2L = 7'h27;

  // Lanes used per link and octets per frame for each mode group.
  localparam logic [3:0] LANES_DEC8 = 4'h1;
  localparam logic [3:0] LANES_BYP = 4'h3;
  localparam logic [2:0] OCTETS_SGL = 3'h2;
  localparam logic [2:0] OCTETS_DUAL = 3'h4;
  localparam logic [2:0] OCTETS_BYP = 3'h2;

  // Frames per multiframe, held as count minus one.
  localparam logic [7:0] KM1_MIN = 8'h03;
  localparam logic [7:0] KM1_MAX = 8'hFF;
  localparam logic [8:0] K_STEP_DDC = 9'h001;
  localparam logic [8:0] K_STEP_BYP = 9'h004;

  // Values taken while reset is applied.
  localparam logic [6:0] RST_MODE = MODE_DUAL_DEC8_2L;
  localparam logic [7:0] RST_KM1 = 8'h1F;
  localparam logic [7:0] RST_DID = 8'h00;

  typedef enum logic [1:0] {
    SHM_CRC12 = 2'b00,
    SHM_FEC = 2'b01
  } jtlm_shm_t;
endpackage

// *** verification/jtlm_lane_mapper_test.sv ***
// Self-checking bench for the lane mapper.
`timescale 1ns/10ps
module jtlm_lane_mapper_test
  import jtlm_pkg::*;
;
  logic core_clk, arst_n = 0, clkEn = 1, cfgLoad = 0, frameValid = 0;
  logic [6:0] linkModeSelect = 7'h27;
  logic [7:0] framesPerMultiframeMinusOne = 8'h1F, deviceIdCfg = 8'h00;
  logic [1:0] syncHeaderMode = 2'h0;
  logic [11:0] overrangeThresholdZero = 12'h400;
  logic [11:0] overrangeThresholdOne = 12'h800, peakA = 12'h900;
  logic [11:0] peakB = 12'h800;
  logic [14:0] ddcAI = 15'h4ABC, ddcAQ = 15'h0123;
  logic [14:0] ddcBI = 15'h7FFF, ddcBQ = 15'h2D55;
  logic [47:0] bypassA = 48'h123456789ABC, bypassB = 48'hFEDCBA987654;
  logic [NUM_LANES-1:0][LANE_BITS-1:0] laneData, expLane;
  logic [NUM_LANES-1:0] laneEnable;
  logic [NUM_LANES-1:0][2:0] laneIdent;
  logic [7:0] deviceIdA, deviceIdB, activeKm1, rxFrames;
  logic [6:0] activeMode;
  logic [2:0] octetsPerFrame;
  logic syncUseCrc12, syncUseFec, frameOut, multiframeEnd, cfgError;
  logic [14:0] rxAI, rxAQ, rxBI, rxBQ;
  logic [3:0] rxFlags;
  logic [11:0] mfe;
  int bad_count = 0;
  int n_compared = 0;
  jtlm_lane_mapper u_dut (.core_clk, .arst_n, .clkEn, .cfgLoad,
    .linkModeSelect, .framesPerMultiframeMinusOne, .syncHeaderMode,
    .deviceIdCfg, .overrangeThresholdZero, .overrangeThresholdOne,
    .frameValid, .ddcAI, .ddcAQ, .ddcBI, .ddcBQ, .peakA, .peakB, .bypassA,
    .bypassB, .laneData, .laneEnable, .laneIdent, .deviceIdA, .deviceIdB,
    .octetsPerFrame, .activeMode, .activeKm1, .syncUseCrc12, .syncUseFec,
    .frameOut, .multiframeEnd, .cfgError);
  jtlm_rx_model u_rx (.core_clk, .arst_n, .frameOut, .laneData,
    .rxMode(linkModeSelect), .rxAI, .rxAQ, .rxBI, .rxBQ, .rxFlags, .rxFrames);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cfg(input logic [6:0] m, input logic [7:0] k,
    input logic [1:0] s);
    @(negedge core_clk);
    linkModeSelect = m;
    framesPerMultiframeMinusOne = k;
    syncHeaderMode = s;
    cfgLoad = 1'b1;
    @(negedge core_clk);
    cfgLoad = 1'b0;
    @(negedge core_clk);
  endtask
  // Sends one frame, then checks every lane against expLane.
  task automatic frame();
    @(negedge core_clk);
    frameValid = 1'b1;
    @(negedge core_clk);
    frameValid = 1'b0;
    check(frameOut, 1'b1);
    for (int i = 0; i < NUM_LANES; i++)
      check(laneData[i], expLane[i]);
  endtask
  // Refused requests must leave the FEC setup with K-1 of 3 in force.
  task automatic refused();
    check(cfgError, 1'b1);
    check(activeMode, MODE_DUAL_DEC8_2L);
    check(activeKm1, 8'h03);
    check(syncUseFec, 1'b1);
  endtask
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check(activeMode, RST_MODE);
    check(activeKm1, RST_KM1);
    check({syncUseCrc12, syncUseFec}, 2'b10);
    check(deviceIdB, 8'h01);
    for (int i = 0; i < NUM_LANES; i++)
      check(laneIdent[i], i % 8);
    cfg(MODE_DUAL_DEC8_2L, 8'h03, 2'b01);
    check({syncUseCrc12, syncUseFec, cfgError}, 3'b010);
    cfg(7'h05, 8'h07, 2'b00);
    refused();
    cfg(MODE_DUAL_DEC8_2L, 8'h02, 2'b00);
    refused();
    cfg(MODE_DUAL_DEC8_2L, 8'h07, 2'b10);
    refused();
    cfg(MODE_DUAL_DEC8_2L, 8'h07, 2'b11);
    refused();
    cfg(MODE_DUAL_BYP_6L, 8'h06, 2'b00);
    refused();
    cfg(MODE_DUAL_BYP_6L, 8'h07, 2'b00);
    check({syncUseCrc12, cfgError, activeKm1}, {2'b10, 8'h07});
    expLane = '0;
    for (int i = 0; i < 3; i++)
    begin
      expLane[i] = {bypassA[47-16*i -: 16], 16'h0000};
      expLane[i+8] = {bypassB[47-16*i -: 16], 16'h0000};
    end
    frame();
    check(laneEnable, 16'h0707);
    check(octetsPerFrame, OCTETS_BYP);
    cfg(MODE_DUAL_DEC8_2L, 8'h03, 2'b00);
    expLane = '0;
    expLane[0] = {ddcAI, 1'b1, ddcAQ, 1'b1};
    expLane[8] = {ddcBI, 1'b1, ddcBQ, 1'b0};
    frame();
    @(negedge core_clk);
    check({rxAI, rxAQ, rxBI, rxBQ}, {ddcAI, ddcAQ, ddcBI, ddcBQ});
    check(rxFlags, 4'b1110);
    check(laneEnable, 16'h0101);
    check(octetsPerFrame, OCTETS_DUAL);
    peakA = 12'h500;
    for (int j = 0; j < 2; j++)
    begin
      cfg(j ? MODE_SGL_DEC8_2L_ALT : MODE_SGL_DEC8_2L, 8'h03, 2'b00);
      expLane = '0;
      expLane[0] = {ddcAI, 1'b1, 16'h0000};
      expLane[8] = {ddcAQ, 1'b0, 16'h0000};
      frame();
      @(negedge core_clk);
      check({rxAI, rxAQ, rxFlags[3:2]}, {ddcAI, ddcAQ, 2'b10});
      check(octetsPerFrame, OCTETS_SGL);
    end
    @(negedge core_clk);
    frameValid = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge core_clk);
      mfe[i] = multiframeEnd;
      check(frameOut, 1'b1);
    end
    frameValid = 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < 8; i++)
      check(mfe[i], mfe[i+4]);
    check($countones(mfe[3:0]), 1);
    check(mfe, 12'h888);
    check(rxFrames, 8'd16);
    clkEn = 1'b0;
    frameValid = 1'b1;
    deviceIdCfg = 8'hFF;
    repeat (2) @(negedge core_clk);
    check({frameOut, multiframeEnd, deviceIdA}, 10'h000);
    frameValid = 1'b0;
    clkEn = 1'b1;
    repeat (2) @(negedge core_clk);
    check({deviceIdA, deviceIdB}, 16'hFF00);
    deviceIdCfg = 8'h3C;
    repeat (2) @(negedge core_clk);
    check({deviceIdA, deviceIdB}, 16'h3C3D);
    finish_test();
  end
endmodule

// *** verification/jtlm_rx_model.sv ***
// Receiver-side deframer model that recovers words from lane frames.
`timescale 1ns/10ps
module jtlm_rx_model
  import jtlm_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic frameOut, // Pulse: a new frame is on the lanes.
  input wire logic [NUM_LANES-1:0][LANE_BITS-1:0] laneData, // Lane frames.
  input wire logic [6:0] rxMode, // Mode the receiver is set to.
  output logic [DDC_BITS-1:0] rxAI, // Channel A I word.
  output logic [DDC_BITS-1:0] rxAQ, // Channel A Q word.
  output logic [DDC_BITS-1:0] rxBI, // Channel B I word.
  output logic [DDC_BITS-1:0] rxBQ, // Channel B Q word.
  output logic [3:0] rxFlags, // Flags with AI, AQ, BI, BQ.
  output logic [7:0] rxFrames // Frames seen since reset.
);
  logic [DDC_BITS-1:0] next_rxAI, next_rxAQ, next_rxBI, next_rxBQ;
  logic [3:0] next_rxFlags;
  logic [7:0] next_rxFrames;
  always_comb
  begin
    next_rxAI = rxAI;
    next_rxAQ = rxAQ;
    next_rxBI = rxBI;
    next_rxBQ = rxBQ;
    next_rxFlags = rxFlags;
    next_rxFrames = rxFrames;
    if (frameOut)
    begin
      next_rxFrames = rxFrames + 8'h01;
      next_rxAI = laneData[0][31:17];
      next_rxFlags[3] = laneData[0][16];
      if (rxMode == MODE_DUAL_DEC8_2L)
      begin
        next_rxAQ = laneData[0][15:1];
        next_rxFlags[2] = laneData[0][0];
        next_rxBI = laneData[8][31:17];
        next_rxFlags[1] = laneData[8][16];
        next_rxBQ = laneData[8][15:1];
        next_rxFlags[0] = laneData[8][0];
      end
      else
      begin
        next_rxAQ = laneData[8][31:17];
        next_rxFlags[2] = laneData[8][16];
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {rxAI, rxAQ, rxBI, rxBQ, rxFlags, rxFrames} <= '0;
    end
    else
    begin
      {rxAI, rxAQ} <= {next_rxAI, next_rxAQ};
      {rxBI, rxBQ} <= {next_rxBI, next_rxBQ};
      rxFlags <= next_rxFlags;
      rxFrames <= next_rxFrames;
    end
  end
endmodule
